/* File: hdl/icd_collision.sv */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module icd_collision
    import icd_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe_n
);

    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    logic [1:0] sda_sync_q;
    logic [1:0] scl_sync_q;
    logic       sda_prev_q;
    logic       scl_prev_q;
    logic       sda;
    logic       scl;

    // Two stages before any logic reads the bus lines
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sda_sync_q <= 2'h3;
            scl_sync_q <= 2'h3;
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_prev_q <= sda_sync_q[1];
            scl_prev_q <= scl_sync_q[1];
        end
    end
    assign sda = sda_sync_q[1];
    assign scl = scl_sync_q[1];

    //--------------------------------------------------------------
    // Registers and sequencer state
    //--------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] reload_q;
    logic [7:0] brg_q;
    logic       bcol_q;
    logic       event_q;
    logic       stopd_q;
    logic       startd_q;
    icd_state_t state_q;
    logic       sda_drv_q;
    logic       scl_drv_q;
    logic       brg_zero;
    logic       wr_en;
    logic       rd_en;
    logic       collide;
    logic       done;
    logic       load_brg;
    logic       bus_stop;
    logic       bus_start;
    logic       port_on;

    assign port_on   = ctrl_q[ICD_CTRL_EN];
    assign wr_en     = psel && penable && pwrite;
    assign rd_en     = psel && penable && !pwrite;
    assign brg_zero  = (brg_q == 8'h00);
    assign bus_stop  = scl && sda && !sda_prev_q && scl_prev_q;
    assign bus_start = scl && !sda && sda_prev_q && scl_prev_q;

    // Collision detection per state, combinational
    always_comb begin
        collide  = 1'b0;
        done     = 1'b0;
        load_brg = 1'b0;
        case (state_q)
            ICD_S_WAIT: begin
                collide = !sda || !scl;
            end
            ICD_S_T1: begin
                collide  = sda && !scl;
                load_brg = !sda;
            end
            ICD_R_SCLH: begin
                collide  = scl && !sda;
                load_brg = scl;
            end
            ICD_R_T1: begin
                collide  = !scl && sda;
                load_brg = !sda;
            end
            ICD_P_SCLH: load_brg = scl;
            ICD_A_SCLH: load_brg = scl;
            ICD_P_T1: begin
                collide = !scl;
            end
            ICD_P_T2: begin
                collide = brg_zero && !sda;
                done    = brg_zero && sda;
            end
            ICD_S_T2: done = brg_zero;
            ICD_R_T2: done = brg_zero;
            ICD_A_T2: done = brg_zero;
            default: begin
                collide  = 1'b0;
            end
        endcase
        if (!port_on) begin
            collide = 1'b0;
        end
    end

    // Bit-period counter: loads on demand or in idle, else counts down to zero, then reloads
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            brg_q <= 8'h00;
        end else if (load_brg || (state_q == ICD_IDLE)) begin
            brg_q <= reload_q;
        end else if (!brg_zero) begin
            brg_q <= brg_q - 8'h01;
        end else begin
            brg_q <= reload_q;
        end
    end

    // Condition sequencer and line drivers
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !port_on) begin
            state_q   <= ICD_IDLE;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
        end else if (collide) begin
            state_q   <= ICD_IDLE;
            sda_drv_q <= 1'b0;
            scl_drv_q <= 1'b0;
        end else begin
            case (state_q)
                ICD_IDLE: begin
                    if (ctrl_q[ICD_CTRL_START]) begin
                        state_q   <= ICD_S_WAIT;
                        sda_drv_q <= 1'b0;
                        scl_drv_q <= 1'b0;
                    end else if (ctrl_q[ICD_CTRL_RESTRT]) begin
                        state_q   <= ICD_R_T0;
                        sda_drv_q <= 1'b0;
                    end else if (ctrl_q[ICD_CTRL_STOP]) begin
                        state_q   <= ICD_P_SDAL;
                        sda_drv_q <= 1'b1;
                    end else if (ctrl_q[ICD_CTRL_ACK]) begin
                        state_q   <= ICD_A_T1;
                        scl_drv_q <= 1'b1;
                    end
                end
                ICD_S_WAIT: state_q <= ICD_S_T1;
                ICD_S_T1: begin
                    if (!sda || brg_zero) begin
                        sda_drv_q <= 1'b1;
                        state_q   <= ICD_S_T2;
                    end
                end
                ICD_S_T2: begin
                    if (brg_zero) begin
                        scl_drv_q <= 1'b1;
                        state_q   <= ICD_IDLE;
                    end
                end
                ICD_R_T0: begin
                    if (brg_zero && sda) begin
                        scl_drv_q <= 1'b0;
                        state_q   <= ICD_R_SCLH;
                    end
                end
                ICD_R_SCLH: begin
                    if (scl) begin
                        state_q <= ICD_R_T1;
                    end
                end
                ICD_R_T1: begin
                    if (!sda) begin
                        sda_drv_q <= 1'b1;
                        state_q   <= ICD_R_T2;
                    end else if (brg_zero) begin
                        sda_drv_q <= 1'b1;
                        state_q   <= ICD_R_T2;
                    end
                end
                ICD_R_T2: begin
                    if (brg_zero) begin
                        scl_drv_q <= 1'b1;
                        state_q   <= ICD_IDLE;
                    end
                end
                ICD_P_SDAL: begin
                    if (!sda) begin
                        scl_drv_q <= 1'b0;
                        state_q   <= ICD_P_SCLH;
                    end
                end
                ICD_P_SCLH: begin
                    if (scl) begin
                        state_q <= ICD_P_T1;
                    end
                end
                ICD_P_T1: begin
                    if (brg_zero) begin
                        sda_drv_q <= 1'b0;
                        state_q   <= ICD_P_T2;
                    end
                end
                ICD_P_T2: begin
                    if (brg_zero) begin
                        state_q <= ICD_IDLE;
                    end
                end
                ICD_A_T1: begin
                    if (brg_zero) begin
                        scl_drv_q <= 1'b0;
                        state_q   <= ICD_A_SCLH;
                    end
                end
                ICD_A_SCLH: begin
                    if (scl) begin
                        state_q <= ICD_A_T2;
                    end
                end
                ICD_A_T2: begin
                    if (brg_zero) begin
                        scl_drv_q <= 1'b1;
                        state_q   <= ICD_IDLE;
                    end
                end
                default: state_q <= ICD_IDLE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // APB register file
    //--------------------------------------------------------------
    // Control: request bits clear on completion or collision
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q   <= ICD_CTRL_RST;
            reload_q <= ICD_RELOAD_RST;
        end else begin
            if (wr_en && (paddr == ICD_ADDR_CTRL)) begin
                ctrl_q <= pwdata[7:0];
            end else if (wr_en && (paddr == ICD_ADDR_RELOAD)) begin
                reload_q <= pwdata[7:0];
            end else if (collide) begin
                ctrl_q[4:0] <= 5'h00;
            end else if (state_q != ICD_IDLE && (done || (brg_zero &&
                         (state_q == ICD_S_T2 || state_q == ICD_R_T2)))) begin
                ctrl_q[4:0] <= 5'h00;
            end
            if (!port_on && !(wr_en && (paddr == ICD_ADDR_CTRL))) begin
                ctrl_q[4:0] <= 5'h00;
            end
        end
    end

    // Status: hardware set wins over write-one-to-clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !port_on) begin
            bcol_q   <= 1'b0;
            event_q  <= 1'b0;
            stopd_q  <= 1'b0;
            startd_q <= 1'b0;
        end else begin
            if (wr_en && paddr == ICD_ADDR_STATUS && pwdata[ICD_STAT_BCOL]) begin
                bcol_q <= 1'b0;
            end
            if (wr_en && paddr == ICD_ADDR_STATUS && pwdata[ICD_STAT_EVENT]) begin
                event_q <= 1'b0;
            end
            if (collide) begin
                bcol_q <= 1'b1;
            end
            if (bus_stop || done) begin
                event_q <= 1'b1;
            end
            if (bus_stop) begin
                stopd_q  <= 1'b1;
                startd_q <= 1'b0;
            end else if (bus_start) begin
                startd_q <= 1'b1;
                stopd_q  <= 1'b0;
            end
        end
    end

    // Read mux, zero-wait answer; unmapped reads zero with error
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == ICD_ADDR_CTRL) begin
                    prdata <= {24'h000000, ctrl_q};
                end else if (paddr == ICD_ADDR_RELOAD) begin
                    prdata <= {24'h000000, reload_q};
                end else if (paddr == ICD_ADDR_STATUS) begin
                    prdata <= {27'h0000000, (state_q != ICD_IDLE), startd_q,
                               stopd_q, event_q, bcol_q};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // Pin outputs, open drain, enable low when pulling
    //--------------------------------------------------------------
    assign sda_o    = 1'b0;
    assign scl_o    = 1'b0;
    assign sda_oe_n = !sda_drv_q;
    assign scl_oe_n = !scl_drv_q;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    start_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_S_WAIT && port_on && !scl) |=> bcol_q && state_q == ICD_IDLE)
        else $error("start with scl low did not collide");
    start_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_S_WAIT) |-> sda_oe_n && scl_oe_n)
        else $error("start began with a line driven");
    start_scl_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_S_T1 && port_on && sda && !scl) |=> bcol_q && sda_oe_n)
        else $error("start scl low not flagged");
    start_early_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_S_T1 && port_on && !sda && scl) |=> !sda_oe_n && !$rose(bcol_q))
        else $error("early sda low mishandled");
    start_second_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_S_T2 && port_on && !brg_zero) |=> !$rose(bcol_q))
        else $error("collision in second start count");
    rs_case1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_R_SCLH && port_on && scl && !sda) |=> bcol_q && state_q == ICD_IDLE)
        else $error("restart case one missed");
    rs_case2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_R_T1 && port_on && !scl && sda) |=> bcol_q)
        else $error("restart case two missed");
    stop_case1_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_P_T2 && port_on && brg_zero && !sda) |=> bcol_q && ctrl_q[2] == 1'b0)
        else $error("stop case one missed");
    stop_case2_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ICD_P_T1 && port_on && !scl) |=> bcol_q && scl_oe_n && sda_oe_n)
        else $error("stop case two missed");
    bus_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port_on && bus_stop) |=> event_q && stopd_q)
        else $error("bus stop not reported");
    count_reload_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (port_on && scl && state_q inside {ICD_R_SCLH, ICD_P_SCLH}) |=> brg_q == reload_q)
        else $error("counter not reloaded when scl rose");
    start_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ICD_S_T2 ##1 state_q == ICD_IDLE);
    rs_coll_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ICD_R_T1 && collide);
    stop_done_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ICD_P_T2 && done);

endmodule

/* File: hdl/icd_pkg.sv */
package icd_pkg;
    // Register byte offsets on APB
    localparam logic [11:0] ICD_ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ICD_ADDR_RELOAD = 12'h004;
    localparam logic [11:0] ICD_ADDR_STATUS = 12'h008;
    // Control register fields
    localparam int          ICD_CTRL_START  = 0;
    localparam int          ICD_CTRL_RESTRT = 1;
    localparam int          ICD_CTRL_STOP   = 2;
    localparam int          ICD_CTRL_ACK    = 4;
    localparam int          ICD_CTRL_EN     = 5;
    // Status register fields
    localparam int          ICD_STAT_BCOL   = 0;
    localparam int          ICD_STAT_EVENT  = 1;
    localparam int          ICD_STAT_STOPD  = 2;
    localparam int          ICD_STAT_STARTD = 3;
    localparam int          ICD_STAT_BUSY   = 4;
    // Reset values
    localparam logic [7:0]  ICD_RELOAD_RST  = 8'h09;
    localparam logic [7:0]  ICD_CTRL_RST    = 8'h00;

    // Sequencer states, Gray coded along each condition
    typedef enum logic [3:0] {
        ICD_IDLE   = 4'h0,
        ICD_S_WAIT = 4'h1,
        ICD_S_T1   = 4'h3,
        ICD_S_T2   = 4'h2,
        ICD_R_T0   = 4'h6,
        ICD_R_SCLH = 4'h7,
        ICD_R_T1   = 4'h5,
        ICD_R_T2   = 4'h4,
        ICD_P_SDAL = 4'hC,
        ICD_P_SCLH = 4'hD,
        ICD_P_T1   = 4'hF,
        ICD_P_T2   = 4'hE,
        ICD_A_T1   = 4'hA,
        ICD_A_SCLH = 4'hB,
        ICD_A_T2   = 4'h9
    } icd_state_t;
endpackage

/* File: bench/icd_bus_peer.sv */
`timescale 1ns/1ps
// ------------------------------------------
// Other masters and slaves sharing the wires
// ------------------------------------------
module icd_bus_peer (
    input  wire logic sda_oe_n,
    input  wire logic scl_oe_n,
    input  wire logic hold_sda_low,
    input  wire logic hold_scl_low,
    input  wire logic grab_sda_on_scl,
    output logic      sda_i,
    output logic      scl_i
);
    // Wired-AND with pull-ups; holding SCL low is clock stretching
    assign scl_i = scl_oe_n & ~hold_scl_low;
    // Grab pulls SDA in the very cycle SCL is let go, so no sync skew hides it
    assign sda_i = sda_oe_n & ~hold_sda_low & ~(grab_sda_on_scl & scl_oe_n);
endmodule

/* File: bench/icd_collision_tb.sv */
`timescale 1ns/1ps
module icd_collision_tb;
    import icd_pkg::*;
    // ------------------
    // Stimulus and wires
    // ------------------
    localparam logic [31:0] EN_W = 32'h1 << ICD_CTRL_EN;
    localparam logic [31:0] RLD  = 32'h03;
    logic        ref_clk      = 1'b0;
    logic        rst_n        = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [11:0] paddr        = 12'h000;
    logic [31:0] pwdata       = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sda_i;
    logic        sda_oe_n;
    logic        scl_i;
    logic        scl_oe_n;
    logic        hold_sda     = 1'b0;
    logic        hold_scl     = 1'b0;
    logic        grab_sda     = 1'b0;
    logic [31:0] rq;
    logic        re;
    int          mismatches   = 0;
    int          compares     = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    icd_collision dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sda_i(sda_i), .sda_o(), .sda_oe_n(sda_oe_n), .scl_i(scl_i),
        .scl_o(), .scl_oe_n(scl_oe_n));
    icd_bus_peer peer_u (.sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n), .hold_sda_low(hold_sda),
        .hold_scl_low(hold_scl), .grab_sda_on_scl(grab_sda), .sda_i(sda_i), .scl_i(scl_i));

    // -------------
    // Shared helpers
    // -------------
    task automatic summarize();
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic give_up();
        mismatches++;
        summarize();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) give_up();
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Polls a request bit until the port drops it
    task automatic wait_req_done(input int b);
        int n;
        for (n = 0; n < 200; n++) begin
            rd(ICD_ADDR_CTRL);
            if (rq[b] === 1'b0) break;
        end
        if (n == 200) give_up();
    endtask

    task automatic wait_line(input logic use_scl, input logic v, output int cyc);
        for (cyc = 0; cyc < 500; cyc++) begin
            @(posedge ref_clk);
            if ((use_scl ? scl_oe_n : sda_oe_n) === v) break;
        end
        if (cyc == 500) give_up();
    endtask

    // ---------
    // Scenarios
    // ---------
    task automatic t_regs();
        rd(ICD_ADDR_RELOAD);
        chk(rq, {24'h0, ICD_RELOAD_RST});
        rd(ICD_ADDR_CTRL);
        chk(rq, {24'h0, ICD_CTRL_RST});
        rd(12'h0FC);
        chk1(re, 1'b1);
        chk(rq, 32'h0);
        wr(ICD_ADDR_RELOAD, RLD);
        rd(ICD_ADDR_RELOAD);
        chk(rq, RLD);
    endtask

    // A line already low when the start begins; later a peer stop on the bus
    task automatic t_start_coll();
        for (int i = 0; i < 2; i++) begin
            hold_sda <= (i == 0);
            hold_scl <= (i == 1);
            repeat (4) @(posedge ref_clk);
            wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_START));
            wait_req_done(ICD_CTRL_START);
            chk1(sda_oe_n, 1'b1);
            chk1(scl_oe_n, 1'b1);
            rd(ICD_ADDR_STATUS);
            chk1(rq[ICD_STAT_BCOL], 1'b1);
            wr(ICD_ADDR_STATUS, 32'h3);
            hold_sda <= 1'b0;
            hold_scl <= 1'b0;
            repeat (6) @(posedge ref_clk);
            rd(ICD_ADDR_STATUS);
            chk(rq & 32'h3, (i == 0) ? 32'h2 : 32'h0);
        end
    endtask

    // Clean start with a peer pulling SCL during the second count
    task automatic t_start_ok();
        int n;
        wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_START));
        wait_line(1'b0, 1'b0, n);
        hold_scl <= 1'b1;
        @(posedge ref_clk);
        hold_scl <= 1'b0;
        wait_line(1'b1, 1'b0, n);
        chk(n + 2, RLD + 1);
        wait_req_done(ICD_CTRL_START);
        rd(ICD_ADDR_STATUS);
        chk1(rq[ICD_STAT_BCOL], 1'b0);
        chk1(sda_oe_n, 1'b0);
        chk1(scl_oe_n, 1'b0);
    endtask

    // Clean run stretches SCL; bad run pulls SDA low as SCL rises
    task automatic t_restart(input logic bad);
        hold_scl <= ~bad;
        grab_sda <= bad;
        wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_RESTRT));
        if (!bad) begin
            repeat (30) @(posedge ref_clk);
            rd(ICD_ADDR_CTRL);
            chk1(rq[ICD_CTRL_RESTRT], 1'b1);
            hold_scl <= 1'b0;
        end
        wait_req_done(ICD_CTRL_RESTRT);
        rd(ICD_ADDR_STATUS);
        chk1(rq[ICD_STAT_BCOL], bad);
        chk1(sda_oe_n, bad);
        chk1(scl_oe_n, bad);
        grab_sda <= 1'b0;
        wr(ICD_ADDR_STATUS, 32'h3);
    endtask

    // Bad run keeps SDA low after the port lets it go
    task automatic t_stop(input logic bad);
        hold_sda <= bad;
        wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_STOP));
        wait_req_done(ICD_CTRL_STOP);
        rd(ICD_ADDR_STATUS);
        chk1(rq[ICD_STAT_BCOL], bad);
        chk1(sda_oe_n, 1'b1);
        chk1(scl_oe_n, 1'b1);
        if (!bad) chk1(rq[ICD_STAT_STOPD], 1'b1);
        hold_sda <= 1'b0;
        wr(ICD_ADDR_STATUS, 32'h3);
    endtask

    // Another master moves a line during the first start count
    task automatic t_start_race(input logic on_scl);
        int n;
        wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_START));
        hold_sda <= !on_scl;
        hold_scl <= on_scl;
        if (!on_scl) begin
            wait_line(1'b0, 1'b0, n);
            chk1(n < RLD + 1, 1'b1);
            hold_sda <= 1'b0;
            wait_line(1'b1, 1'b0, n);
            chk(n + 1, RLD + 1);
        end
        wait_req_done(ICD_CTRL_START);
        hold_scl <= 1'b0;
        rd(ICD_ADDR_STATUS);
        chk1(rq[ICD_STAT_BCOL], on_scl);
        chk1(rq[ICD_STAT_STARTD], !on_scl);
        chk1(sda_oe_n, on_scl);
        chk1(scl_oe_n, on_scl);
        wr(ICD_ADDR_STATUS, 32'h3);
    endtask

    // Acknowledge pulse: SCL let go for one period, then pulled low again
    task automatic t_ack();
        wr(ICD_ADDR_CTRL, EN_W | (32'h1 << ICD_CTRL_ACK));
        wait_req_done(ICD_CTRL_ACK);
        rd(ICD_ADDR_STATUS);
        chk(rq & 32'h3, 32'h2);
        chk1(scl_oe_n, 1'b0);
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        give_up();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_start_coll();
        t_start_race(1'b1);
        t_start_ok();
        t_restart(1'b0);
        t_stop(1'b0);
        t_start_ok();
        t_restart(1'b1);
        t_start_ok();
        t_stop(1'b1);
        t_start_race(1'b0);
        t_ack();
        summarize();
    end
endmodule
